//--- common/fws_pkg.sv
/*
  Package for the flash write/erase sequencing host: timing constants,
  command codes, the host command struct and the sequencer states.
  Assumes a 125 MHz system clock.
*/
`default_nettype none
package fws_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS        = 8000;
  localparam int RESET_RECOVERY_NS    = 1000;  // reset_recovery_delay
  localparam int BUSY_INDICATION_NS   = 200;   // busy_indication_delay
  localparam int RELOCK_NS            = 200;   // relock_delay
  localparam int UNLOCK_SETUP_NS      = 200;
  localparam int STROBE_LOW_NS        = 70;
  localparam int STROBE_HIGH_NS       = 30;
  localparam int ADDR_SETUP_NS        = 80;
  localparam int ADDR_HOLD_NS         = 10;
  localparam int PROGRAM_DURATION_US  = 6;     // program_duration
  localparam int PARAM_ERASE_MS       = 300;
  localparam int MAIN_ERASE_MS        = 600;
  localparam int PARAM_ERASE_MAX_S    = 7;
  localparam int MAIN_ERASE_MAX_S     = 14;

  // Least times round up, at least one cycle
  function automatic int ns_min(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ns_min

  localparam int RS_CYC   = ns_min(RESET_RECOVERY_NS);
  localparam int WB_CYC   = ns_min(BUSY_INDICATION_NS);
  localparam int REL_CYC  = ns_min(RELOCK_NS);
  localparam int RHS_CYC  = ns_min(UNLOCK_SETUP_NS);
  localparam int WP_CYC   = ns_min(STROBE_LOW_NS > ADDR_SETUP_NS ?
                                   STROBE_LOW_NS : ADDR_SETUP_NS);
  localparam int WPH_CYC  = ns_min(STROBE_HIGH_NS);
  localparam int AH_CYC   = ns_min(ADDR_HOLD_NS);
  localparam int PGM_CYC  = ns_min(PROGRAM_DURATION_US * 1000);
  localparam longint PERA_MAX_CYC =
    longint'(PARAM_ERASE_MAX_S) * 1000000000 * 1000 / CLK_PERIOD_PS;
  localparam longint MERA_MAX_CYC =
    longint'(MAIN_ERASE_MAX_S) * 1000000000 * 1000 / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // Flash commands and status bits
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_PROGRAM  = 8'h40;
  localparam logic [7:0] CMD_ERASE    = 8'h20;
  localparam logic [7:0] CMD_CONFIRM  = 8'hd0;
  localparam logic [7:0] CMD_STATUS   = 8'h70;
  localparam logic [7:0] CMD_READ     = 8'hff;
  localparam int         READY_BIT    = 7;     // ready_flag position

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FWS_OP_PROGRAM     = 2'h0,
    FWS_OP_PARAM_ERASE = 2'h1,
    FWS_OP_MAIN_ERASE  = 2'h2
  } fws_op_t;

  typedef struct packed {
    fws_op_t     op;
    logic        boot;      // target is the protected boot block
    logic [17:0] addr;
    logic [15:0] data;
  } fws_cmd_t;

  typedef enum logic [8:0] {
    ST_RESET   = 9'h001,
    ST_RECOVER = 9'h002,
    ST_IDLE    = 9'h004,
    ST_SETUP   = 9'h008,
    ST_LOW     = 9'h010,
    ST_HIGH    = 9'h020,
    ST_WAITWB  = 9'h040,
    ST_POLL    = 9'h080,
    ST_RELOCK  = 9'h100
  } fws_state_t;
endpackage : fws_pkg
`default_nettype wire

//--- hdl/fws_host.sv
/*
  Host-side sequencer driving a parallel flash through its pins:
  reset recovery, two-cycle write/erase commands with write-strobe
  controlled timing, status polling and boot block unlock/relock.
  Assumes flash read data is synchronous to mclk and valid one cycle
  after the output enable drops.
*/
`timescale 1ns/1ps
`default_nettype none
module fws_host
  import fws_pkg::*;
#(
  parameter longint PERA_MAX = PERA_MAX_CYC,
  parameter longint MERA_MAX = MERA_MAX_CYC,
  parameter int     RS_WAIT  = RS_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire fws_cmd_t    cmd,
  input  wire logic        word_mode,
  output logic             cmd_ready,
  output logic             done,
  output logic             fail,
  output logic             timeout,
  output logic [7:0]       status,
  output logic             reset_powerdown_n,
  output logic             boot_unlock,
  output logic             word_width,
  output logic             chip_en_n,
  output logic             write_en_n,
  output logic             out_en_n,
  output logic [17:0]      flash_addr,
  output logic [15:0]      flash_dq_o,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_i
);

  // ---------------------------------------------------------------
  // State and counters
  // ---------------------------------------------------------------
  // Sequencer registers; timers count mclk cycles
  fws_state_t  state_ff;
  fws_cmd_t    cur_ff;
  logic        phase_ff;     // 0 setup cycle, 1 confirm/data cycle
  logic [31:0] cnt_ff;       // short timer
  logic [63:0] op_ff;        // elapsed operation time
  logic        rd_ff;        // status read in flight

  // Give-up limit per operation; program has no limit of its own
  function automatic logic [63:0] op_max(input fws_op_t op);
    unique case (op)
      FWS_OP_PROGRAM:     return 64'hffffffff_ffffffff;
      FWS_OP_PARAM_ERASE: return PERA_MAX[63:0];
      FWS_OP_MAIN_ERASE:  return MERA_MAX[63:0];
      default:            return MERA_MAX[63:0];
    endcase
  endfunction : op_max

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Main state machine with all pin outputs registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff          <= ST_RESET;
      cur_ff            <= '0;
      phase_ff          <= 1'b0;
      cnt_ff            <= '0;
      op_ff             <= '0;
      rd_ff             <= 1'b0;
      cmd_ready         <= 1'b0;
      done              <= 1'b0;
      fail              <= 1'b0;
      timeout           <= 1'b0;
      status            <= 8'h00;
      reset_powerdown_n <= 1'b0;
      boot_unlock       <= 1'b0;
      word_width        <= 1'b0;
      chip_en_n         <= 1'b1;
      write_en_n        <= 1'b1;
      out_en_n          <= 1'b1;
      flash_addr        <= '0;
      flash_dq_o        <= '0;
      flash_dq_oe       <= 1'b0;
    end else begin
      done    <= 1'b0;
      cnt_ff  <= cnt_ff + 32'h1;
      unique case (state_ff)
        ST_RESET: begin
          // Release the flash reset, then wait out recovery
          reset_powerdown_n <= 1'b1;
          cnt_ff            <= '0;
          state_ff          <= ST_RECOVER;
        end
        ST_RECOVER: begin
          if (cnt_ff >= 32'(RS_WAIT - 1)) begin
            state_ff  <= ST_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        ST_IDLE: begin
          // Latch the command and set width, unlock, address pins
          if (cmd_valid) begin
            cur_ff      <= cmd;
            cmd_ready   <= 1'b0;
            fail        <= 1'b0;
            timeout     <= 1'b0;
            word_width  <= word_mode;
            boot_unlock <= cmd.boot;
            flash_addr  <= cmd.addr;
            phase_ff    <= 1'b0;
            cnt_ff      <= '0;
            state_ff    <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Address and unlock set before strobe low; data driven in the same cycle
          chip_en_n   <= 1'b0;
          flash_dq_oe <= 1'b1;
          if (!phase_ff)
            flash_dq_o <= {8'h00, cur_ff.op == FWS_OP_PROGRAM ?
                           CMD_PROGRAM : CMD_ERASE};
          else if (cur_ff.op == FWS_OP_PROGRAM)
            flash_dq_o <= word_width ? cur_ff.data
                                     : {8'h00, cur_ff.data[7:0]};
          else
            flash_dq_o <= {8'h00, CMD_CONFIRM};
          if (!cur_ff.boot || phase_ff == 1'b0 ||
              cnt_ff >= 32'(RHS_CYC - WP_CYC)) begin
            write_en_n <= 1'b0;
            cnt_ff     <= '0;
            state_ff   <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (cnt_ff >= 32'(WP_CYC - 1)) begin
            // Rising strobe edge ends the cycle; data held past it
            write_en_n <= 1'b1;
            cnt_ff     <= '0;
            state_ff   <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (cnt_ff >= 32'(WPH_CYC > AH_CYC ? WPH_CYC - 1 : AH_CYC - 1))
          begin
            chip_en_n   <= 1'b1;
            flash_dq_oe <= 1'b0;
            cnt_ff      <= '0;
            if (!phase_ff) begin
              phase_ff <= 1'b1;
              state_ff <= ST_SETUP;
            end else begin
              op_ff    <= '0;
              state_ff <= ST_WAITWB;
            end
          end
        end
        ST_WAITWB: begin
          // No status trusted before the busy delay
          op_ff <= op_ff + 64'h1;
          if (cnt_ff >= 32'(WB_CYC - 1)) begin
            chip_en_n <= 1'b0;
            out_en_n  <= 1'b0;
            rd_ff     <= 1'b0;
            state_ff  <= ST_POLL;
          end
        end
        ST_POLL: begin
          // Address held unchanged while the flash is busy
          op_ff <= op_ff + 64'h1;
          rd_ff <= 1'b1;
          // First poll cycle only turns the flash output on
          if (rd_ff) begin
            status <= flash_dq_i[7:0];
            if (flash_dq_i[READY_BIT]) begin
              fail      <= (cur_ff.op == FWS_OP_PROGRAM) ?
                           (op_ff < 64'(PGM_CYC)) : 1'b0;
              out_en_n  <= 1'b1;
              chip_en_n <= 1'b1;
              cnt_ff    <= '0;
              state_ff  <= ST_RELOCK;
            end else if (op_ff >= op_max(cur_ff.op)) begin
              timeout   <= 1'b1;
              out_en_n  <= 1'b1;
              chip_en_n <= 1'b1;
              cnt_ff    <= '0;
              state_ff  <= ST_RELOCK;
            end
          end
        end
        ST_RELOCK: begin
          // Unlock dropped only after ready or timeout; wait out relock
          boot_unlock <= 1'b0;
          if (cnt_ff >= 32'(REL_CYC - 1)) begin
            done      <= 1'b1;
            cmd_ready <= 1'b1;
            state_ff  <= ST_IDLE;
          end
        end
        default: state_ff <= ST_RESET;
      endcase
    end
  end

endmodule : fws_host
`default_nettype wire

//--- verif/fws_host_properties.sv
/* Checker for the flash host pins and handshake.
   Bound into fws_host; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module fws_host_properties
  import fws_pkg::*;
#(parameter int RS_WAIT = RS_CYC) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        cmd_ready,
  input wire logic        word_mode,
  input wire logic        done,
  input wire logic        fail,
  input wire logic        timeout,
  input wire logic [7:0]  status,
  input wire logic        reset_powerdown_n,
  input wire logic        boot_unlock,
  input wire logic        word_width,
  input wire logic        chip_en_n,
  input wire logic        write_en_n,
  input wire logic        out_en_n,
  input wire logic [17:0] flash_addr,
  input wire logic        flash_dq_oe
);
  logic [7:0] rs_ff;
  logic [7:0] wb_ff;
  // Cycles since flash reset release and since strobe high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rs_ff <= 8'h00;
      wb_ff <= 8'h00;
    end else begin
      if (!reset_powerdown_n) rs_ff <= 8'h00;
      else if (rs_ff != 8'hff) rs_ff <= rs_ff + 8'h01;
      if (!write_en_n) wb_ff <= 8'h00;
      else if (wb_ff != 8'hff) wb_ff <= wb_ff + 8'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_reset_recovery: assert property
    ($fell(write_en_n) |-> rs_ff >= RS_WAIT)
    else $error("write strobe too soon after flash reset");
  a_poll_after_busy: assert property
    ($fell(out_en_n) |-> wb_ff >= WB_CYC)
    else $error("status read before busy delay");
  a_addr_held: assert property
    (!cmd_ready && !$past(cmd_ready) |-> $stable(flash_addr))
    else $error("address moved during operation");
  a_unlock_kept: assert property
    ($fell(boot_unlock) |-> status[READY_BIT] || timeout)
    else $error("unlock dropped before ready");
  a_width_taken: assert property
    ($fell(cmd_ready) |-> word_width == $past(word_mode))
    else $error("width pin not taken with command");
  a_strobe_in_ce: assert property
    (!write_en_n |-> !chip_en_n && flash_dq_oe && out_en_n)
    else $error("write strobe outside chip select");
  // Nine cycles of 8 ns cover the 70 ns strobe, not the 80 ns address setup
  a_strobe_width: assert property
    ($fell(write_en_n) |-> !write_en_n [*8] ##1 !write_en_n)
    else $error("write strobe too short");
  c_fail: cover property (done && fail);
  c_timeout: cover property (done && timeout);
  c_relock: cover property ($fell(boot_unlock));
endmodule : fws_host_properties
bind fws_host fws_host_properties #(.RS_WAIT(RS_WAIT)) u_fws_host_properties (
  .mclk, .rst_n, .cmd_ready, .word_mode, .done, .fail, .timeout, .status,
  .reset_powerdown_n, .boot_unlock, .word_width, .chip_en_n, .write_en_n,
  .out_en_n, .flash_addr, .flash_dq_oe);
`default_nettype wire

//--- verif/fws_flash_model.sv
/* Behavioural flash: two-cycle commands, busy count, status reads.
   Assumes mclk-synchronous pins; mode 1 ends early, mode 2 stalls. */
`timescale 1ns/1ps
`default_nettype none
module fws_flash_model
  import fws_pkg::*;
#(
  parameter logic [15:0] PGM = 16'h0320,
  parameter logic [15:0] ERA = 16'h04b0
) (
  input  wire logic        mclk,
  input  wire logic [1:0]  mode,
  input  wire logic        reset_powerdown_n,
  input  wire logic        boot_unlock,
  input  wire logic        word_width,
  input  wire logic        chip_en_n,
  input  wire logic        write_en_n,
  input  wire logic        out_en_n,
  input  wire logic [15:0] flash_dq_o,
  output logic      [15:0] flash_dq_i,
  output logic      [15:0] got_data,
  output logic             got_ok
);
  logic        we_ff, ce_ff, arm_ff, era_ff, wr_end;
  logic [15:0] busy_ff;
  // Write ends where the low overlap of both strobes ends
  assign wr_end = !(we_ff || ce_ff) && (write_en_n || chip_en_n);
  // Command decode, busy count, status on reads
  always_ff @(posedge mclk) begin
    we_ff <= write_en_n;
    ce_ff <= chip_en_n;
    if (!reset_powerdown_n) begin
      arm_ff <= 1'b0;
      busy_ff <= 16'h0000;
      flash_dq_i <= 16'h5a5a;
    end else begin
      if (busy_ff != 16'h0000) busy_ff <= busy_ff - 16'h0001;
      if (wr_end && busy_ff == 16'h0000 && !arm_ff) begin
        arm_ff <= 1'b1;
        era_ff <= flash_dq_o[7:0] == CMD_ERASE;
      end else if (wr_end && busy_ff == 16'h0000) begin
        arm_ff <= 1'b0;
        busy_ff <= mode == 2'h1 ? 16'h0064 :
                   mode == 2'h2 ? 16'h2328 : era_ff ? ERA : PGM;
        got_data <= word_width ? flash_dq_o : {8'h00, flash_dq_o[7:0]};
        got_ok <= boot_unlock;
      end
      if (!chip_en_n && !out_en_n)
        flash_dq_i <= busy_ff == 16'h0000 ? 16'h0080 : 16'h0000;
      else flash_dq_i <= ~flash_dq_i;
    end
  end
endmodule : fws_flash_model
`default_nettype wire

//--- verif/fws_host_bench.sv
/* Bench for fws_host facing the behavioural flash.
   Needs fws_pkg, the flash model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module fws_host_bench
  import fws_pkg::*;
;
  logic        mclk, rst_n, cmd_valid, word_mode, cmd_ready, done, fail;
  logic        timeout, reset_powerdown_n, boot_unlock, word_width, got_ok;
  logic        chip_en_n, write_en_n, out_en_n, flash_dq_oe;
  logic [1:0]  mode;
  logic [7:0]  status;
  logic [17:0] flash_addr;
  logic [15:0] flash_dq_o, flash_dq_i, got_data;
  fws_cmd_t    cmd;
  int          failures, samples_checked;
  fws_host #(.PERA_MAX(2000), .MERA_MAX(3000)) u_fws_host (
    .mclk, .rst_n, .cmd_valid, .cmd, .word_mode, .cmd_ready, .done, .fail,
    .timeout, .status, .reset_powerdown_n, .boot_unlock, .word_width,
    .chip_en_n, .write_en_n, .out_en_n, .flash_addr, .flash_dq_o,
    .flash_dq_oe, .flash_dq_i);
  fws_flash_model u_fws_flash_model (
    .mclk, .mode, .reset_powerdown_n, .boot_unlock, .word_width, .chip_en_n,
    .write_en_n, .out_en_n, .flash_dq_o, .flash_dq_i, .got_data, .got_ok);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // One command: request, wait taken, wait done, judge end state
  task automatic run(input fws_op_t op, input logic b, wm,
                     input logic [15:0] d, input logic [1:0] md,
                     input logic [15:0] exp);
    int n;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, boot: b, addr: {2'h1, d}, data: d};
    word_mode <= wm;
    mode <= md;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 500);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (done !== 1'b1 && n < 12000);
    chk("done pulse", 16'h1, {15'h0, done});
    chk("fail timeout status", exp, {6'h0, fail, timeout, status});
    chk("address held", d, flash_addr[15:0]);
  endtask : run
  task automatic t_reset();
    int n;
    chk("flash reset", 16'h0, {15'h0, reset_powerdown_n});
    rst_n <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 500);
    chk("recovery", 16'h1, {15'h0, n > RS_CYC});
    $display("reset test done");
  endtask : t_reset
  task automatic t_prog();
    run(FWS_OP_PROGRAM, 1'b0, 1'b1, 16'hbeef, 2'h0, 16'h0080);
    chk("word data", 16'hbeef, got_data);
    chk("boot kept locked", 16'h0, {15'h0, got_ok});
    run(FWS_OP_PROGRAM, 1'b0, 1'b0, 16'h12c3, 2'h0, 16'h0080);
    chk("byte data", 16'h00c3, got_data);
    chk("width pin", 16'h0, {15'h0, word_width});
    $display("program test done");
  endtask : t_prog
  task automatic t_boot();
    run(FWS_OP_PROGRAM, 1'b1, 1'b1, 16'h0f0f, 2'h0, 16'h0080);
    chk("boot unlocked", 16'h1, {15'h0, got_ok});
    chk("relocked", 16'h0, {15'h0, boot_unlock});
    $display("boot test done");
  endtask : t_boot
  task automatic t_faults();
    run(FWS_OP_PROGRAM, 1'b0, 1'b1, 16'h5a5a, 2'h1, 16'h0280);
    run(FWS_OP_PARAM_ERASE, 1'b0, 1'b1, 16'h0000, 2'h0, 16'h0080);
    run(FWS_OP_MAIN_ERASE, 1'b0, 1'b1, 16'h4000, 2'h0, 16'h0080);
    run(FWS_OP_PARAM_ERASE, 1'b0, 1'b1, 16'h2000, 2'h2, 16'h0100);
    $display("fault and erase test done");
  endtask : t_faults
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    word_mode = 1'b0;
    mode = 2'h0;
    failures = 0;
    samples_checked = 0;
    repeat (5) @(posedge mclk);
    t_reset();
    t_prog();
    t_boot();
    t_faults();
    final_report();
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    final_report();
  end
endmodule : fws_host_bench
`default_nettype wire
